// >>> rtl/mpoc_pkg.sv
// Package for the micro power off reset and refresh controller
package mpoc_pkg;
    // Register offsets (configuration index space)
    localparam logic [7:0] MPOC_ADDR_PLL_TIMER = 8'h8f;
    localparam logic [7:0] MPOC_ADDR_MISC3 = 8'hba;
    localparam logic [7:0] MPOC_ADDR_GPO = 8'hc0;
    localparam logic [7:0] MPOC_ADDR_STATUS = 8'hc1;
    // Field positions
    localparam int MPOC_BIT_MP_REFRESH = 2;
    localparam int MPOC_BIT_SELF_REFRESH = 3;
    // Reset values
    localparam logic [7:0] MPOC_RST_PLL_TIMER = 8'h04;
    localparam logic [7:0] MPOC_RST_MISC3 = 8'h00;
    localparam logic [7:0] MPOC_RST_GPO = 8'h00;
    // PLL timer unit: one count per millisecond
    localparam int MPOC_CLK_HZ = 10_000_000;
    localparam int MPOC_TICK_US = 1000;
    localparam int MPOC_TICK_CYC = MPOC_CLK_HZ / 1_000_000 * MPOC_TICK_US;
    // Controller states
    typedef enum logic [2:0] {
        MPOC_S_COLD = 3'b000,
        MPOC_S_RUN = 3'b001,
        MPOC_S_MPOFF = 3'b010,
        MPOC_S_PLLWAIT = 3'b011,
        MPOC_S_EXITCBR = 3'b100
    } mpoc_state_t;
    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } mpoc_bus_t;
endpackage

// >>> rtl/mpoc_ctl.sv
// Micro power off reset sequencer, refresh retention and termination control
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
// Operation
// RULE_01 - Refresh enable bit two of BAh, default off
// RULE_02 - Enabled refresh runs throughout micro power off
// RULE_03 - Refresh type latched at power-good low
// RULE_04 - Master reset low clears refresh enable
// RULE_05 - Power-good reset leaves refresh enable intact
// RULE_06 - Self-refresh exit issues exactly one CBR
// RULE_07 - Reset output high while PLLs gated
// RULE_08 - Either reset input asserts reset output
// RULE_09 - Cold boot holds reset until both released
// RULE_10 - Master reset restores defaults, timer 4 ms
// RULE_11 - Source holds master reset one second
// RULE_12 - Warm master reset pulse at least 250 ms
// RULE_13 - Power-good entry asserts reset, held throughout
// RULE_14 - PLL timer value kept across power off
// RULE_15 - Exit holds reset until timer expires
// RULE_16 - Termination on unless both inputs high
// RULE_17 - Power-good high, master low equals both low
// RULE_18 - GP outputs take preset level when off
// RULE_19 - System never starts directly in power off
// RULE_20 - Without power off, share one reset source
// RULE_21 - Power off logic runs from 32 kHz
// RULE_22 - Master reset clears all, flags RAM invalid
// RULE_23 - Power-good release runs full power-up sequence
// RULE_24 - Reset inputs synchronised before use
module mpoc_ctl
    import mpoc_pkg::*;
#(
    parameter int TICK_CYC = MPOC_TICK_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Reset inputs, low active at the pins
    input wire logic masterResetIn_n,
    input wire logic powerGoodReset_n,
    // Slow clock tick from the 32 kHz oscillator
    input wire logic slowTick,
    // Register port
    input wire mpoc_bus_t bus,
    output logic [7:0] rdData,
    // Reset, refresh and termination outputs
    output logic systemResetOut,
    output logic refreshEnable,
    output logic refreshSlowClk,
    output logic selfRefreshReq,
    output logic cbrPulse,
    output logic forceTerm,
    output logic cpuResetPulse,
    output logic ramInvalid,
    output logic gpOutputA,
    output logic gpOutputB
);
    initial begin
        if (TICK_CYC < 1) $error("TICK_CYC must be at least one");
        // Tick counter is 16 bits wide
        if (TICK_CYC > 65536) $error("TICK_CYC must fit the 16-bit tick counter");
    end

    // Synchronisers; first stage feeds only the second
    logic [1:0] mrSync1_ff, mrSync2_ff;
    always_ff @(posedge clk_sys) begin
        mrSync1_ff <= {masterResetIn_n, powerGoodReset_n}; // RULE_24
        mrSync2_ff <= mrSync1_ff;
    end
    wire logic mrLow = ~mrSync2_ff[1];
    wire logic pgLow = ~mrSync2_ff[0];
    // sys_rst acts as a master reset as well
    wire logic masterClr = sys_rst | mrLow;

    // Registers
    logic [7:0] pllTimer_ff, misc3_ff, gpo_ff, rdData_ff;
    logic ramInvalid_ff;
    logic latchedSelf_ff;
    mpoc_state_t state_ff, nxt_state;
    logic [7:0] msCnt_ff, nxt_msCnt;
    logic [15:0] tickCnt_ff, nxt_tickCnt;

    // Register decode
    wire logic wrPll = bus.wr & (bus.addr == MPOC_ADDR_PLL_TIMER);
    wire logic wrMisc = bus.wr & (bus.addr == MPOC_ADDR_MISC3);
    wire logic wrGpo = bus.wr & (bus.addr == MPOC_ADDR_GPO);
    wire logic wrStat = bus.wr & (bus.addr == MPOC_ADDR_STATUS);
    wire logic inOff = (state_ff == MPOC_S_MPOFF);
    wire logic [7:0] statusWord = {4'h0, ramInvalid_ff, latchedSelf_ff, state_ff[1:0]};
    wire logic [7:0] rdMux =
        (bus.addr == MPOC_ADDR_PLL_TIMER) ? pllTimer_ff :
        (bus.addr == MPOC_ADDR_MISC3) ? misc3_ff :
        (bus.addr == MPOC_ADDR_GPO) ? gpo_ff :
        (bus.addr == MPOC_ADDR_STATUS) ? statusWord : 8'h00;

    // Config registers: master reset only; power-good leaves them (RULE_05, RULE_14)
    always_ff @(posedge clk_sys) begin
        if (masterClr) begin
            pllTimer_ff <= MPOC_RST_PLL_TIMER; // RULE_10
            misc3_ff <= MPOC_RST_MISC3; // RULE_01 RULE_04
            gpo_ff <= MPOC_RST_GPO;
        end else begin
            if (wrPll) pllTimer_ff <= bus.wdata;
            if (wrMisc) misc3_ff <= bus.wdata;
            if (wrGpo) gpo_ff <= bus.wdata;
        end
    end

    // RAM invalid flag: set by master reset, set beats software clear
    always_ff @(posedge clk_sys) begin
        if (masterClr) ramInvalid_ff <= 1'b1; // RULE_22
        else if (wrStat && bus.wdata[3]) ramInvalid_ff <= 1'b0;
    end

    // Read data one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (sys_rst) rdData_ff <= 8'h00;
        else rdData_ff <= bus.rd ? rdMux : 8'h00;
    end

    // Refresh type frozen at entry to power off
    wire logic enterOff = (state_ff == MPOC_S_RUN) & pgLow & ~mrLow;
    always_ff @(posedge clk_sys) begin
        if (masterClr) latchedSelf_ff <= 1'b0;
        else if (enterOff) latchedSelf_ff <= misc3_ff[MPOC_BIT_SELF_REFRESH]; // RULE_03
    end

    // Sequencer next state
    wire logic refreshEnOff = misc3_ff[MPOC_BIT_MP_REFRESH];
    // Done on the last tick of the last millisecond, so the wait is timer times tick
    // A zero timer still waits one tick rather than none
    wire logic timerDone = (msCnt_ff <= 8'h01) & (tickCnt_ff == 16'h0000);
    always_comb begin
        nxt_state = state_ff;
        nxt_msCnt = msCnt_ff;
        nxt_tickCnt = tickCnt_ff;
        case (state_ff)
            MPOC_S_COLD: begin
                if (!mrLow && !pgLow) nxt_state = MPOC_S_RUN; // RULE_09
            end
            MPOC_S_RUN: begin
                if (pgLow) nxt_state = MPOC_S_MPOFF; // RULE_13
            end
            MPOC_S_MPOFF: begin
                if (!pgLow) begin
                    nxt_state = MPOC_S_PLLWAIT; // RULE_23
                    nxt_msCnt = pllTimer_ff; // RULE_14
                    nxt_tickCnt = 16'(TICK_CYC - 1);
                end
            end
            MPOC_S_PLLWAIT: begin
                if (pgLow) nxt_state = MPOC_S_MPOFF;
                else if (timerDone) begin
                    nxt_state = (refreshEnOff && latchedSelf_ff) ? MPOC_S_EXITCBR
                                                                 : MPOC_S_RUN; // RULE_15
                end else if (tickCnt_ff == 16'h0000) begin
                    nxt_msCnt = msCnt_ff - 8'h01;
                    nxt_tickCnt = 16'(TICK_CYC - 1);
                end else begin
                    nxt_tickCnt = tickCnt_ff - 16'h0001;
                end
            end
            MPOC_S_EXITCBR: nxt_state = MPOC_S_RUN; // RULE_06
            default: nxt_state = MPOC_S_COLD;
        endcase
    end

    // State registers; master reset forces cold state
    always_ff @(posedge clk_sys) begin
        if (masterClr) begin
            state_ff <= MPOC_S_COLD;
            msCnt_ff <= 8'h00;
            tickCnt_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            msCnt_ff <= nxt_msCnt;
            tickCnt_ff <= nxt_tickCnt;
        end
    end

    // Output decode
    wire logic nxtRstOut = (nxt_state != MPOC_S_RUN) | mrLow | pgLow; // RULE_07 RULE_08
    wire logic nxtTerm = mrLow | pgLow; // RULE_16 RULE_17
    wire logic nxtInOff = (nxt_state == MPOC_S_MPOFF);
    wire logic nxtRefEn = ~nxtInOff | (refreshEnOff & ~mrLow); // RULE_01 RULE_02
    wire logic nxtCbr = (state_ff == MPOC_S_EXITCBR); // RULE_06
    // CPU reset pulses on every power-up exit, with or without the CBR step
    wire logic leaveSeq = (state_ff == MPOC_S_PLLWAIT) | (state_ff == MPOC_S_EXITCBR);
    wire logic nxtCpuRst = leaveSeq & (nxt_state == MPOC_S_RUN); // RULE_23

    // Registered outputs
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            systemResetOut <= 1'b1;
            forceTerm <= 1'b1;
            refreshEnable <= 1'b1;
            refreshSlowClk <= 1'b0;
            selfRefreshReq <= 1'b0;
            cbrPulse <= 1'b0;
            cpuResetPulse <= 1'b0;
            gpOutputA <= 1'b0;
            gpOutputB <= 1'b0;
        end else begin
            systemResetOut <= nxtRstOut;
            forceTerm <= nxtTerm;
            refreshEnable <= nxtRefEn;
            refreshSlowClk <= nxtInOff & nxtRefEn & slowTick; // RULE_21
            selfRefreshReq <= nxtInOff & nxtRefEn & latchedSelf_ff;
            cbrPulse <= nxtCbr;
            cpuResetPulse <= nxtCpuRst;
            gpOutputA <= nxtInOff ? gpo_ff[0] : gpo_ff[2]; // RULE_18
            gpOutputB <= nxtInOff ? gpo_ff[1] : gpo_ff[3];
        end
    end
    assign rdData = rdData_ff;
    assign ramInvalid = ramInvalid_ff;

    // Checks
    chk_term_inputs: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_16
        forceTerm == $past(nxtTerm))
        else $error("termination does not follow reset inputs");
    chk_rst_follows: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_08
        (mrLow | pgLow) |=> systemResetOut)
        else $error("reset output not asserted");
    chk_mr_clears: assert property (@(posedge clk_sys) // RULE_04
        mrLow |=> !misc3_ff[MPOC_BIT_MP_REFRESH] && pllTimer_ff == MPOC_RST_PLL_TIMER)
        else $error("master reset did not restore defaults");
    chk_pg_keeps: assert property (@(posedge clk_sys) disable iff (masterClr) // RULE_05
        (pgLow && !wrMisc) |=> $stable(misc3_ff))
        else $error("power-good changed refresh enable");
    sequence exitSelf;
        (state_ff == MPOC_S_PLLWAIT) && (nxt_state == MPOC_S_EXITCBR);
    endsequence
    sequence cbrOnce;
        cbrPulse ##1 !cbrPulse;
    endsequence
    chk_one_cbr: assert property (@(posedge clk_sys) disable iff (masterClr) // RULE_06
        exitSelf |=> ##1 cbrOnce)
        else $error("self-refresh exit not one refresh cycle");
    chk_off_refresh: assert property (@(posedge clk_sys) disable iff (masterClr) // RULE_02
        (inOff && refreshEnOff) |=> refreshEnable)
        else $error("refresh dropped in power off");
    chk_off_norefresh: assert property (@(posedge clk_sys) disable iff (masterClr) // RULE_01
        (nxtInOff && !refreshEnOff) |=> !refreshEnable)
        else $error("refresh running while disabled");
    chk_wait_rst: assert property (@(posedge clk_sys) disable iff (masterClr) // RULE_15
        (state_ff == MPOC_S_PLLWAIT && !timerDone) |=> systemResetOut)
        else $error("reset released before timer expiry");
    // Cold state keeps the core in reset
    chk_cold_hold: assert property (@(posedge clk_sys) disable iff (masterClr) // RULE_09
        (state_ff == MPOC_S_COLD && nxt_state == MPOC_S_COLD) |=> systemResetOut)
        else $error("reset released in cold state");
    // Master reset marks retained RAM invalid
    chk_mr_ram: assert property (@(posedge clk_sys) // RULE_22
        masterClr |=> ramInvalid_ff)
        else $error("master reset did not flag ram invalid");
    // Power-good low from run enters power off with reset high
    chk_pg_entry: assert property (@(posedge clk_sys) disable iff (masterClr) // RULE_13
        (state_ff == MPOC_S_RUN && pgLow) |=> systemResetOut && inOff)
        else $error("power off entry without reset");
    // PLLs stay gated in power off, so reset stays high
    chk_off_hold: assert property (@(posedge clk_sys) disable iff (masterClr) // RULE_07
        inOff |=> systemResetOut)
        else $error("reset dropped while PLLs gated");
    // Wait starts from the preserved timer value
    chk_timer_load: assert property (@(posedge clk_sys) disable iff (masterClr) // RULE_14
        (inOff && !pgLow) |=> msCnt_ff == $past(pllTimer_ff))
        else $error("PLL timer value not preserved");
    // Refresh type frozen at entry
    chk_type_latch: assert property (@(posedge clk_sys) disable iff (masterClr) // RULE_03
        enterOff |=> latchedSelf_ff == $past(misc3_ff[MPOC_BIT_SELF_REFRESH]))
        else $error("refresh type not latched at entry");
    // Termination on for any low input
    chk_term_on: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_17
        (mrLow || pgLow) |=> forceTerm)
        else $error("termination off with a reset input low");
    // Termination off only with both inputs high
    chk_term_off: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_16
        (!mrLow && !pgLow) |=> !forceTerm)
        else $error("termination on with both inputs high");
    // Preset levels on the general outputs in power off
    chk_gp_preset: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_18
        nxtInOff |=> gpOutputA == $past(gpo_ff[0]) && gpOutputB == $past(gpo_ff[1]))
        else $error("general outputs not at preset level");
    // Slow refresh clock only in power off
    chk_slow_gate: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE_21
        !nxtInOff |=> !refreshSlowClk)
        else $error("slow refresh clock outside power off");
    // End of the PLL wait resets the CPU
    chk_cpu_pulse: assert property (@(posedge clk_sys) disable iff (masterClr) // RULE_23
        (state_ff == MPOC_S_PLLWAIT && nxt_state == MPOC_S_RUN) |=> cpuResetPulse)
        else $error("no CPU reset after PLL wait");
endmodule

// >>> test/mpoc_partner.sv
// Model of the power supplies and power-on reset sources
`timescale 1ns/1ps
module mpoc_partner #(
    parameter int COLD_HOLD = 20,
    parameter int TICK_DIV = 8
) (
    // Clock
    input wire logic clk_sys,
    // Requests from the bench
    input wire logic holdMaster,
    input wire logic holdPg,
    // Pins toward the controller
    output logic masterResetIn_n,
    output logic powerGoodReset_n,
    output logic slowTick
);
    int unsigned age;
    int unsigned div;
    // Power just applied: both sources low
    initial begin
        age = 0;
        div = 0;
        masterResetIn_n = 1'b0;
        powerGoodReset_n = 1'b0;
        slowTick = 1'b0;
    end
    // Pins move just after the edge, like registered supervisors
    always @(posedge clk_sys) begin
        age <= age + 1;
        div <= (div == TICK_DIV - 1) ? 0 : div + 1;
        slowTick <= (div == 0);
        // Master held through power-up so clocks settle
        masterResetIn_n <= !(holdMaster || age < COLD_HOLD);
        // Power-good only after full power-up, never straight into off
        powerGoodReset_n <= !(holdPg || age < COLD_HOLD);
    end
endmodule

// >>> test/tb_micro_power_off_reset_refresh_ctl.sv
// Self-checking bench for the micro power off controller
`timescale 1ns/1ps
module tb_micro_power_off_reset_refresh_ctl;
    import mpoc_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic holdMaster = 1'b0;
    logic holdPg = 1'b0;
    logic masterResetIn_n, powerGoodReset_n, slowTick;
    mpoc_bus_t bus = '0;
    logic [7:0] rdData;
    logic systemResetOut, refreshEnable, refreshSlowClk, selfRefreshReq, cbrPulse;
    logic forceTerm, cpuResetPulse, ramInvalid, gpOutputA, gpOutputB;
    int n_fail = 0;
    int n_checks = 0;
    // Short ms tick keeps PLL waits to a few cycles
    mpoc_ctl #(.TICK_CYC(4)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .masterResetIn_n(masterResetIn_n), .powerGoodReset_n(powerGoodReset_n),
        .slowTick(slowTick), .bus(bus), .rdData(rdData), .systemResetOut(systemResetOut),
        .refreshEnable(refreshEnable), .refreshSlowClk(refreshSlowClk),
        .selfRefreshReq(selfRefreshReq), .cbrPulse(cbrPulse), .forceTerm(forceTerm),
        .cpuResetPulse(cpuResetPulse), .ramInvalid(ramInvalid), .gpOutputA(gpOutputA),
        .gpOutputB(gpOutputB));
    mpoc_partner PARTNER (.clk_sys(clk_sys), .holdMaster(holdMaster), .holdPg(holdPg),
        .masterResetIn_n(masterResetIn_n), .powerGoodReset_n(powerGoodReset_n),
        .slowTick(slowTick));
    // 10 MHz clock
    always #50 clk_sys = ~clk_sys;
    task end_of_test();
        if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask
    // Read data only stands in the cycle after the strobe
    task rd(input logic [7:0] a, input logic [7:0] e, input string msg);
        @(posedge clk_sys);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1;
        chk(rdData === e, msg);
    endtask
    task wait_run();
        for (int i = 0; i < 80 && systemResetOut !== 1'b0; i++) cyc(1);
        chk(systemResetOut === 1'b0 && forceTerm === 1'b0, "no release");
    endtask
    task t_cold();
        cyc(2);
        chk(systemResetOut === 1'b1 && forceTerm === 1'b1, "cold state");
        rd(MPOC_ADDR_PLL_TIMER, MPOC_RST_PLL_TIMER, "timer default");
        rd(MPOC_ADDR_MISC3, 8'h00, "misc default");
        rd(8'h55, 8'h00, "unmapped read");
        wait_run();
    endtask
    // One trip through power off and back, refresh setup from misc
    task t_poff(input logic [7:0] misc);
        int cbr;
        int cpu;
        int rel;
        logic hold;
        logic seen;
        cbr = 0;
        cpu = 0;
        rel = -1;
        hold = 1'b1;
        seen = 1'b0;
        wr(MPOC_ADDR_MISC3, misc);
        wr(MPOC_ADDR_PLL_TIMER, 8'h02);
        wr(MPOC_ADDR_GPO, 8'h03);
        holdPg <= 1'b1;
        cyc(6);
        chk(systemResetOut === 1'b1 && forceTerm === 1'b1, "entry");
        chk(refreshEnable === misc[2], "refresh on");
        chk(selfRefreshReq === (misc[2] & misc[3]), "refresh type");
        chk(gpOutputA === 1'b1 && gpOutputB === 1'b1, "gp preset");
        repeat (20) begin
            cyc(1);
            hold &= (systemResetOut === 1'b1);
            seen |= (refreshSlowClk === 1'b1);
        end
        chk(hold, "reset dropped");
        chk(seen === misc[2], "slow refresh clock");
        rd(MPOC_ADDR_PLL_TIMER, 8'h02, "timer kept");
        rd(MPOC_ADDR_MISC3, misc, "misc kept");
        chk(ramInvalid === 1'b0, "ram flag set by power-good");
        holdPg <= 1'b0;
        for (int n = 0; n < 40; n++) begin
            cyc(1);
            cbr += int'(cbrPulse === 1'b1);
            cpu += int'(cpuResetPulse === 1'b1);
            if (rel < 0 && systemResetOut === 1'b0) rel = n;
        end
        chk(rel >= 8 && rel <= 24, "pll wait");
        chk(cbr == int'(misc[2] & misc[3]), "cbr count");
        chk(cpu == 1, "cpu reset");
        chk(forceTerm === 1'b0 && gpOutputA === 1'b0 && gpOutputB === 1'b0, "run");
    endtask
    // Warm master reset: power-good high, master low
    task t_master();
        holdMaster <= 1'b1;
        cyc(6);
        chk(systemResetOut === 1'b1 && forceTerm === 1'b1, "master");
        chk(ramInvalid === 1'b1, "ram flag");
        holdMaster <= 1'b0;
        wait_run();
        rd(MPOC_ADDR_MISC3, 8'h00, "misc cleared");
        rd(MPOC_ADDR_PLL_TIMER, MPOC_RST_PLL_TIMER, "timer restored");
        wr(MPOC_ADDR_STATUS, 8'h08);
        cyc(1);
        chk(ramInvalid === 1'b0, "ram flag clear again");
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_cold();
        wr(MPOC_ADDR_STATUS, 8'h08);
        cyc(1);
        chk(ramInvalid === 1'b0, "ram flag clear");
        t_poff(8'h0c);
        t_master();
        t_poff(8'h04);
        t_poff(8'h08);
        end_of_test();
    end
    // Watchdog well beyond the expected run
    initial begin
        repeat (3000) @(posedge clk_sys);
        n_fail++;
        end_of_test();
    end
endmodule
